// [src/ebs_map.svh]
// constants for the encoder serial master sequencer
// assumes one fabric clock, one link clock, host-set quasi-static config
`ifndef EBS_MAP_SVH
`define EBS_MAP_SVH

`define EBS_CNT_W      8
`define EBS_FRAME_BITS 8'h04
`define EBS_CRC_BITS   8'h06
`define EBS_MA_REST    1'h1
`define EBS_SCK_REST   1'h0
`define EBS_LDE_LEVEL  1'h0

`endif

// [src/ebs_pkg.sv]
// types for the encoder serial master sequencer
// assumes nothing beyond the constants header
package ebs_pkg;

	// declaration order gives 00, 01, 10, 11
	typedef enum logic [1:0] {
		phase_idle,
		phase_clock_out,
		phase_clock_and_capture,
		phase_capture_tail
	} ebs_phase_type;

	function automatic logic [1:0] ebs_to_gray(input logic [1:0] b);
		return {b[1], b[1] ^ b[0]};
	endfunction

	function automatic logic [1:0] ebs_from_gray(input logic [1:0] g);
		return {g[1], g[1] ^ g[0]};
	endfunction

endpackage

// [src/ebs_clock_gen.sv]
// counter-driven clock generator with duty, period and phase align
// assumes period and low length stable while running, low below period
`timescale 1ns/1ps
`default_nettype none
`include "ebs_map.svh"

module ebs_clock_gen #(
	parameter int W = `EBS_CNT_W
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_run,
	input  wire logic         i_align,
	input  wire logic [W-1:0] i_period,
	input  wire logic [W-1:0] i_low_len,
	output logic              o_level,
	output logic              o_rise
);
	import ebs_pkg::*;

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_level;
	wire          wrap = (cnt >= (i_period - W'(1)));

	// parks at period end: first low half full length; align restarts
	assign next_cnt = !i_run ? i_period - W'(1) :
		((i_align || wrap) ? '0 : cnt + W'(1));
	// stopped generator rests high
	assign next_level = !i_run || (next_cnt >= i_low_len);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt     <= '0;
			o_level <= `EBS_MA_REST;
			o_rise  <= 1'h0;
		end else begin
			cnt     <= next_cnt;
			o_level <= next_level;
			o_rise  <= !o_level && next_level;
		end
	end

	AST_GEN_REST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_run |=> o_level)
		else $error("stopped generator not resting high");

	AST_GEN_ALIGN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_align && i_run && (i_low_len != '0) |=> !o_level)
		else $error("align did not restart low half");

	AST_GEN_RISE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_rise |-> o_level && !$past(o_level))
		else $error("rise pulse without rising level");

endmodule // ebs_clock_gen
`default_nettype wire

// [src/ebs_sequencer.sv]
// encoder serial master sequencer: phase machine, MA and shift clocks
// assumes host config is stable while idle; SL is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "ebs_map.svh"

module ebs_sequencer #(
	parameter int CNT_W = `EBS_CNT_W
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_link_clk,
	input  wire logic             i_start,
	input  wire logic             i_force_idle,
	input  wire logic             i_cdm_high,
	input  wire logic [CNT_W-1:0] i_position_bits,
	input  wire logic [CNT_W-1:0] i_shift_count,
	input  wire logic [CNT_W-1:0] i_ma_period,
	input  wire logic [CNT_W-1:0] i_ma_low,
	input  wire logic [CNT_W-1:0] i_shift_period,
	input  wire logic [CNT_W-1:0] i_shift_low,
	input  wire logic             i_sl,
	output logic                  o_ma,
	output logic                  o_receive_shift_clock,
	output logic                  o_line_driver_enable,
	output var ebs_pkg::ebs_phase_type o_phase,
	output logic                  o_start_pulse
);
	import ebs_pkg::*;

	localparam int CFG_W = 2 + 6 * CNT_W;

	// ---------------- fabric clock side ----------------

	logic       start_prev;
	logic       start_tgl;
	logic [1:0] phase_g1;
	logic [1:0] phase_g2;
	logic [1:0] phase_gray;
	wire        start_pulse = i_start && !start_prev;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_prev    <= 1'h0;
			start_tgl     <= 1'h0;
			o_start_pulse <= 1'h0;
		end else begin
			start_prev    <= i_start;
			// toggle carries the one-cycle event into the link domain
			start_tgl     <= start_tgl ^ start_pulse;
			o_start_pulse <= start_pulse;
		end
	end

	// phase comes back gray coded: each step flips one bit only, except the forced return from capture to idle, which flips both
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_g1 <= 2'h0;
			phase_g2 <= 2'h0;
			o_phase  <= phase_idle;
		end else begin
			phase_g1 <= phase_gray;
			phase_g2 <= phase_g1;
			o_phase  <= ebs_phase_type'(ebs_from_gray(phase_g2));
		end
	end

	// ---------------- link clock side ----------------

	logic             start_t1;
	logic             start_t2;
	logic             start_t3;
	logic             sl_s1;
	logic             sl_s2;
	logic             sl_prev;
	logic [CFG_W-1:0] cfg_s1;
	logic [CFG_W-1:0] cfg_s2;

	// config levels: quasi-static, so a plain double flop per bit is enough
	wire [CFG_W-1:0] cfg_in = {i_cdm_high, i_force_idle, i_position_bits,
		i_shift_count, i_ma_period, i_ma_low, i_shift_period, i_shift_low};

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_t1 <= 1'h0;
			start_t2 <= 1'h0;
			start_t3 <= 1'h0;
			sl_s1    <= 1'h1;
			sl_s2    <= 1'h1;
			sl_prev  <= 1'h1;
			cfg_s1   <= '0;
			cfg_s2   <= '0;
		end else begin
			start_t1 <= start_tgl;
			start_t2 <= start_t1;
			start_t3 <= start_t2;
			sl_s1    <= i_sl;
			sl_s2    <= sl_s1;
			sl_prev  <= sl_s2;
			cfg_s1   <= cfg_in;
			cfg_s2   <= cfg_s1;
		end
	end

	wire             cdm_high   = cfg_s2[CFG_W-1];
	wire             force_idle = cfg_s2[CFG_W-2];
	wire [CNT_W-1:0] pos_bits   = cfg_s2[6*CNT_W-1:5*CNT_W];
	wire [CNT_W-1:0] sck_target = cfg_s2[5*CNT_W-1:4*CNT_W];
	wire [CNT_W-1:0] ma_period  = cfg_s2[4*CNT_W-1:3*CNT_W];
	wire [CNT_W-1:0] ma_low     = cfg_s2[3*CNT_W-1:2*CNT_W];
	wire [CNT_W-1:0] sck_period = cfg_s2[2*CNT_W-1:CNT_W];
	wire [CNT_W-1:0] sck_low    = cfg_s2[CNT_W-1:0];

	wire start_link = start_t2 ^ start_t3;
	wire sl_rise    = sl_s2 && !sl_prev;

	// ---------------- phase machine ----------------

	ebs_phase_type phase;
	ebs_phase_type next_phase;

	wire in_idle = (phase == phase_idle);
	wire in_out  = (phase == phase_clock_out);
	wire in_cap  = (phase == phase_clock_and_capture);
	wire in_tail = (phase == phase_capture_tail);

	// first SL rise while clocking MA is the START bit
	wire ack_pulse = in_out && sl_rise;

	logic ma_level;
	logic ma_rise;
	logic ma_done;
	logic sck_level;
	logic sck_rise;
	logic sck_en;
	logic sck_done;
	logic [CNT_W-1:0] ma_cnt;
	logic [CNT_W-1:0] sck_cnt;

	// leave combined phase only once the last MA high half is over
	wire ma_end = in_cap && ma_done && !ma_level;

	always_comb begin
		next_phase = phase;
		case (phase)
			phase_idle: begin
				if (start_link && !force_idle) begin
					next_phase = phase_clock_out;
				end
			end
			phase_clock_out: begin
				// no timeout: acknowledge may be stretched freely
				if (force_idle) begin
					next_phase = phase_idle;
				end else if (ack_pulse) begin
					next_phase = phase_clock_and_capture;
				end
			end
			phase_clock_and_capture: begin
				if (force_idle) begin
					next_phase = phase_idle;
				end else if (ma_end) begin
					next_phase = phase_capture_tail;
				end
			end
			phase_capture_tail: begin
				if (force_idle) begin
					next_phase = phase_idle;
				end
			end
			default: begin
				next_phase = phase_idle;
			end
		endcase
	end

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase      <= phase_idle;
			phase_gray <= 2'h0;
		end else begin
			phase      <= next_phase;
			phase_gray <= ebs_to_gray(next_phase);
		end
	end

	// ---------------- MA clock ----------------

	wire ma_run = in_out || in_cap;

	ebs_clock_gen #(
		.W (CNT_W)
	) u_ma_gen (
		.i_clk     (i_link_clk),
		.i_rst_n   (i_rst_n),
		.i_run     (ma_run),
		.i_align   (1'h0),
		.i_period  (ma_period),
		.i_low_len (ma_low),
		.o_level   (ma_level),
		.o_rise    (ma_rise)
	);

	// MA clocks still owed after START: position, frame and CRC bits
	wire [CNT_W-1:0] ma_target =
		pos_bits + CNT_W'(`EBS_FRAME_BITS) + CNT_W'(`EBS_CRC_BITS);
	wire ma_step  = in_cap && !ma_done && ma_rise;
	wire ma_match = ma_step && (ma_cnt + CNT_W'(1) == ma_target);

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ma_cnt  <= '0;
			ma_done <= 1'h0;
		end else if (!in_cap) begin
			ma_cnt  <= '0;
			ma_done <= 1'h0;
		end else begin
			if (ma_step) begin
				ma_cnt <= ma_cnt + CNT_W'(1);
			end
			if (ma_match) begin
				ma_done <= 1'h1;
			end
		end
	end

	// ---------------- receive shift clock ----------------

	// free runs through capture; the output gate trims it
	wire sck_run = in_cap || in_tail || ack_pulse;

	ebs_clock_gen #(
		.W (CNT_W)
	) u_sck_gen (
		.i_clk     (i_link_clk),
		.i_rst_n   (i_rst_n),
		.i_run     (sck_run),
		.i_align   (ack_pulse),
		.i_period  (sck_period),
		.i_low_len (sck_low),
		.o_level   (sck_level),
		.o_rise    (sck_rise)
	);

	// count may exceed the frame so the receive FIFO reaches its level
	wire sck_step  = sck_en && !sck_done && sck_rise;
	wire sck_match = sck_step && (sck_cnt + CNT_W'(1) == sck_target);

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sck_cnt  <= '0;
			sck_en   <= 1'h0;
			sck_done <= 1'h0;
		end else if (in_idle || force_idle) begin
			sck_cnt  <= '0;
			sck_en   <= 1'h0;
			sck_done <= 1'h0;
		end else begin
			if (ack_pulse) begin
				sck_en <= 1'h1;
			end else if (sck_done && !sck_level) begin
				// close only after the last high half, no runt pulse
				sck_en <= 1'h0;
			end
			if (sck_step) begin
				sck_cnt <= sck_cnt + CNT_W'(1);
			end
			if (sck_match) begin
				sck_done <= 1'h1;
			end
		end
	end

	// ---------------- pin outputs ----------------

	logic next_ma;
	assign next_ma = in_tail ? cdm_high :
		((ma_done || !ma_run) ? 1'h1 : ma_level);

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ma                  <= `EBS_MA_REST;
			o_receive_shift_clock <= `EBS_SCK_REST;
			o_line_driver_enable  <= `EBS_LDE_LEVEL;
		end else begin
			o_ma                  <= next_ma;
			// wired straight to the shift port clock input
			o_receive_shift_clock <= sck_level && sck_en;
			o_line_driver_enable  <= `EBS_LDE_LEVEL;
		end
	end

	// ---------------- assertions ----------------

	AST_START_ONE: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_n)
		start_pulse |=> !start_pulse)
		else $error("start pulse longer than one cycle");

	AST_START_GO: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		in_idle && start_link && !force_idle
		|=> phase == phase_clock_out)
		else $error("start did not enter clock-out");

	AST_IDLE_QUIET: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		in_idle && $past(in_idle) |-> o_ma && !o_receive_shift_clock)
		else $error("activity on encoder pins while idle");

	AST_ACK_GO: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		in_out && sl_rise && !force_idle
		|=> phase == phase_clock_and_capture)
		else $error("START bit did not enter combined phase");

	AST_NO_EARLY_SCK: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		in_out ##1 in_out |-> !o_receive_shift_clock)
		else $error("shift clock before START bit");

	AST_SCK_GATE: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		!sck_en |=> !o_receive_shift_clock)
		else $error("shift clock not gated");

	AST_SCK_BOUND: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		sck_done |-> sck_cnt == sck_target)
		else $error("shift count match wrong");

	AST_MA_DONE: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		ma_done && in_cap |-> ma_cnt == ma_target)
		else $error("MA count after START wrong");

	AST_MA_END: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		ma_end && !force_idle |=> in_tail)
		else $error("MA completion did not enter tail");

	AST_TAIL_CDM: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		in_tail ##1 in_tail |-> o_ma == $past(cdm_high))
		else $error("MA not holding CDM level");

	AST_TAIL_HOLD: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		in_tail && !force_idle |=> in_tail)
		else $error("tail phase left without force");

	AST_LDE_LOW: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n)
		!o_line_driver_enable)
		else $error("line driver enable not low");

	COV_ACK: cover property (@(posedge i_link_clk)
		disable iff (!i_rst_n) in_out ##1 in_cap);

	COV_TAIL: cover property (@(posedge i_link_clk)
		disable iff (!i_rst_n) in_cap ##1 in_tail);

	COV_SCK_DONE: cover property (@(posedge i_link_clk)
		disable iff (!i_rst_n) sck_match);

	COV_BACK_IDLE: cover property (@(posedge i_link_clk)
		disable iff (!i_rst_n) in_tail ##1 in_idle);

endmodule // ebs_sequencer
`default_nettype wire

// [verification/ebs_encoder_model.sv]
// encoder stand-in: ack, start bit, then data msb first on MA rises
// assumes the bench arms it per frame; SL idles high between frames
`timescale 1ns/1ps
`default_nettype none

module ebs_encoder_model (
	input  wire logic        i_arm,
	input  wire logic        i_ma,
	input  wire logic [7:0]  i_ack_len,
	input  wire logic [15:0] i_data,
	output logic             o_sl
);
	int n;

	initial o_sl = 1'h1;

	// updates on MA rise, as a real encoder shifts on the clock
	always @(posedge i_ma or negedge i_arm) begin
		if (!i_arm) begin
			n = 0;
			o_sl = 1'h1;
		end else begin
			n = n + 1;
			if (n <= i_ack_len) begin
				o_sl = 1'h0; // ack stretched by bench choice
			end else if (n == i_ack_len + 1) begin
				o_sl = 1'h1;
			end else if (n <= i_ack_len + 17) begin
				o_sl = i_data[i_ack_len + 17 - n];
			end else begin
				o_sl = 1'h0;
			end
		end
	end
endmodule // ebs_encoder_model

`default_nettype wire

// [verification/ebs_sequencer_tb_top.sv]
// bench for the sequencer: two frames, an abort, idle and reset checks
// assumes the encoder model on SL; shift and MA periods kept equal
`timescale 1ns/1ps
`default_nettype none

module ebs_sequencer_tb_top;
	import ebs_pkg::*;

	logic          clk = 1'h0;
	logic          lclk = 1'h0;
	logic          rst_n = 1'h0;
	logic          start = 1'h0;
	logic          force_idle = 1'h0;
	logic          cdm = 1'h1;
	logic          arm = 1'h0;
	logic [7:0]    ack_len = 8'h01;
	logic [7:0]    pos_bits = 8'h10;
	logic [7:0]    shift_cnt = 8'h20;
	logic [7:0]    per = 8'h08;
	logic [7:0]    ma_low = 8'h04;
	logic [7:0]    sh_low = 8'h02;
	logic [15:0]   data = 16'ha5c3;
	logic          sl;
	logic          ma;
	logic          sck;
	logic          lde;
	logic          pulse;
	ebs_phase_type phase;
	logic [16:0]   cap;
	int            ma_rise, ma_lowc, sck_rise, sck_highc, cycles;
	int            err_total = 0;
	int            checked = 0;

	always #20 clk = ~clk;
	// offset start so the two clocks keep no fixed phase
	initial begin
		#7;
		forever #15 lclk = ~lclk;
	end

	ebs_sequencer i_dut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk),
		.i_start(start), .i_force_idle(force_idle), .i_cdm_high(cdm),
		.i_position_bits(pos_bits), .i_shift_count(shift_cnt),
		.i_ma_period(per), .i_ma_low(ma_low), .i_shift_period(per),
		.i_shift_low(sh_low), .i_sl(sl), .o_ma(ma),
		.o_receive_shift_clock(sck), .o_line_driver_enable(lde),
		.o_phase(phase), .o_start_pulse(pulse)
	);

	ebs_encoder_model i_enc (
		.i_arm(arm), .i_ma(ma), .i_ack_len(ack_len), .i_data(data),
		.o_sl(sl)
	);

	always @(posedge ma) ma_rise++;
	always @(posedge sck) begin
		if (sck_rise < 17) cap = {cap[15:0], sl};
		sck_rise++;
	end
	always @(posedge lclk) begin
		if (ma === 1'h0) ma_lowc++;
		if (sck === 1'h1) sck_highc++;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
		end
	endtask

	task automatic chk_phase(input string what, input ebs_phase_type exp);
		checked++;
		if (phase !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %0h got %0h", what, exp, phase);
		end
	endtask

	// bounded poll; phase crosses domains so it lags by a few cycles
	task automatic wait_phase(input ebs_phase_type p);
		int k;
		k = 0;
		while (phase !== p && k < 5000) begin
			@(negedge clk);
			k++;
		end
		chk_phase("phase", p);
	endtask

	task automatic clear_counts();
		ma_rise = 0;
		ma_lowc = 0;
		sck_rise = 0;
		sck_highc = 0;
		cap = '0;
	endtask

	task automatic t_reset_idle();
		clear_counts();
		repeat (50) @(negedge clk);
		chk("ma rest", 1, ma);
		chk("ldr en", 0, lde);
		chk_phase("reset phase", phase_idle);
		chk("idle ma", 0, ma_rise);
		chk("idle sck", 0, sck_rise);
	endtask

	task automatic t_frame(input int ack, input logic c);
		int pulses;
		@(negedge clk);
		clear_counts();
		ack_len = ack[7:0];
		cdm = c;
		arm = 1'h1;
		start = 1'h1;
		pulses = 0;
		repeat (4) begin
			@(negedge clk);
			pulses += int'(pulse === 1'h1);
		end
		chk("start pulse", 1, pulses);
		wait_phase(phase_clock_out);
		wait_phase(phase_clock_and_capture);
		wait_phase(phase_capture_tail);
		repeat (150) @(negedge clk);
		chk("ma rises", ack + 11 + pos_bits, ma_rise);
		chk("cdm", c, ma);
		chk("sck rises", shift_cnt, sck_rise);
		chk("sck high", shift_cnt * 6, sck_highc);
		chk("capture", {1'h1, data}, cap);
		// duty only measurable when the cdm level rests high
		if (c) chk("ma low", ma_rise * 4, ma_lowc);
		chk("ldr en", 0, lde);
		chk_phase("tail held", phase_capture_tail);
		force_idle = 1'h1;
		start = 1'h0;
		wait_phase(phase_idle);
		@(negedge clk);
		force_idle = 1'h0;
		arm = 1'h0;
		repeat (10) @(negedge clk);
		chk("ma rest", 1, ma);
	endtask

	// abort during clock-out: no ack ever comes, host pulls it back
	task automatic t_abort();
		clear_counts();
		ack_len = 8'hff;
		arm = 1'h1;
		start = 1'h1;
		wait_phase(phase_clock_out);
		repeat (30) @(negedge clk);
		chk_phase("no ack", phase_clock_out);
		chk("sck quiet", 0, sck_rise);
		force_idle = 1'h1;
		start = 1'h0;
		wait_phase(phase_idle);
		@(negedge clk);
		force_idle = 1'h0;
		arm = 1'h0;
		repeat (10) @(negedge clk);
		chk("ma rest", 1, ma);
	endtask

	task automatic conclude();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'h1;
		t_reset_idle();
		t_frame(1, 1'h1);
		t_frame(20, 1'h0);
		t_abort();
		conclude();
	end
endmodule // ebs_sequencer_tb_top

`default_nettype wire
